// ===== logic/drc_pkg.sv
package drc_pkg;

	// multi-function input function codes
	localparam logic [4:0] FN_CODE_MAX = 5'h1b;
	localparam logic [4:0] FN_THREE_WIRE = 5'h11;
	localparam int NUM_INPUTS = 5;
	localparam int STD_INPUTS = 3;

	// control method codes
	localparam logic [1:0] CM_SLIP_COMP = 2'h1;

	// timing
	localparam int CLK_HZ = 125_000_000;
	localparam int PULSE_MIN_MS = 50;
	localparam int PULSE_MIN_CYC = CLK_HZ / 1000 * PULSE_MIN_MS;
	localparam int DWELL_TICK_MS = 100;
	localparam int DWELL_TICK_CYC = CLK_HZ / 1000 * DWELL_TICK_MS;
	localparam logic [6:0] DWELL_TIME_MAX = 7'h64;

	// slip formula divisor, slip in 0.01 Hz, freq in 0.01 Hz
	localparam int SLIP_DIV = 120;
	localparam logic [15:0] NOLOAD_PCT = 16'h0028;

	// motor capacity in 0.1 kW units, 0.1 to 2.2 kW
	localparam logic [4:0] CAP_MIN = 5'h01;
	localparam logic [4:0] CAP_MAX = 5'h16;

	// load inertia codes
	localparam logic [1:0] INERTIA_LOW = 2'h0;
	localparam logic [1:0] INERTIA_TEN = 2'h1;
	localparam logic [1:0] INERTIA_HIGH = 2'h2;

	typedef enum logic [3:0] {
		PH_STOP = 4'b0001,
		PH_DWELL = 4'b0010,
		PH_ACCEL = 4'b0100,
		PH_RUN = 4'b1000
	} drc_phase_t;

	typedef struct packed {
		logic [15:0] rated_current; // 0.1 A
		logic [15:0] slip_freq; // 0.01 Hz
		logic [15:0] no_load_current; // 0.1 A
		logic [6:0] efficiency; // percent
	} drc_motor_t;

	typedef struct packed {
		logic inertia_low;
		logic inertia_ten;
		logic inertia_high;
	} drc_inertia_t;

	typedef struct packed {
		drc_phase_t phase;
		logic run_latch;
		logic dwell_done;
		logic [NUM_INPUTS-1:0] in_prev;
		logic [22:0] pulse_cnt;
		logic pulse_ok;
		logic [23:0] tick_cnt;
		logic [6:0] dwell_cnt;
		logic [15:0] out_freq;
		logic [15:0] slip_add;
		logic [15:0] slip_default;
	} drc_state_t;

endpackage

// ===== logic/drc_run_control.sv
`timescale 1ns/1ns
module drc_run_control
	import drc_pkg::*;
#(
	// timing counts; the bench shortens them to keep runs short
	parameter int PULSE_CYC = PULSE_MIN_CYC,
	parameter int TICK_CYC = DWELL_TICK_CYC
)
(
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_reset,
	// terminals and function codes
	input wire logic [NUM_INPUTS-1:0] i_terminals,
	input wire logic [4:0] i_input_function_code [NUM_INPUTS],
	input wire logic i_advanced_io,
	input wire logic i_stop_closed_n,
	// dwell and speed
	input wire logic [15:0] i_dwell_freq,
	input wire logic [6:0] i_dwell_time,
	input wire logic [15:0] i_target_freq,
	input wire logic [15:0] i_accel_step,
	// slip compensation setup
	input wire logic [1:0] i_control_method_code,
	input wire logic [4:0] i_motor_capacity_setting,
	input wire logic [15:0] i_rated_freq,
	input wire logic [15:0] i_rated_rpm,
	input wire logic [3:0] i_pole_count_setting,
	input wire logic [15:0] i_motor_load_pct,
	input wire logic [1:0] i_load_inertia_setting,
	// status and outputs
	output logic o_run_cmd,
	output logic o_dwell_active,
	output logic o_slip_comp_en,
	output logic [15:0] o_out_freq,
	output logic [15:0] o_slip_default,
	output drc_motor_t o_motor_defaults,
	output drc_inertia_t o_inertia,
	output logic [NUM_INPUTS-1:0] o_code_valid
);

	drc_state_t s_q;
	drc_state_t s_d;
	logic [NUM_INPUTS-1:0] tw_sel;
	logic tw_level;
	logic tw_rise;
	logic [31:0] sync_speed;
	logic [15:0] slip_calc;
	logic [15:0] rated_i;

	function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[16] ? 16'hffff : s[15:0];
	endfunction

	function automatic logic [15:0] step_to(input logic [15:0] cur, input logic [15:0] tgt,
		input logic [15:0] stp);
		logic [15:0] nxt;
		nxt = sat_add(cur, stp);
		return (nxt >= tgt) ? tgt : nxt;
	endfunction

	// terminals 0 to 2 may carry the three-wire function; terminals 3 and 4 only with i_advanced_io
	always_comb begin
		for (int k = 0; k < NUM_INPUTS; k++) begin
			o_code_valid[k] = (i_input_function_code[k] <= FN_CODE_MAX);
			tw_sel[k] = o_code_valid[k] && (i_input_function_code[k] == FN_THREE_WIRE)
				&& (i_advanced_io || k < STD_INPUTS);
		end
	end

	assign tw_level = |(tw_sel & i_terminals);
	assign tw_rise = |(tw_sel & i_terminals & ~s_q.in_prev);

	// synchronous speed in 0.01 Hz: rpm*poles*100/120
	assign sync_speed = (32'(i_rated_rpm) * 32'(i_pole_count_setting) * 32'd100) / 32'(SLIP_DIV);
	assign slip_calc = (32'(i_rated_freq) > sync_speed)
		? 16'(32'(i_rated_freq) - sync_speed) : 16'h0000;

	// linear capacity scaling; exact tables are not modelled
	assign rated_i = 16'(i_motor_capacity_setting) * 16'h0023;

	always_comb begin
		s_d = s_q;
		s_d.in_prev = i_terminals;
		s_d.slip_default = slip_calc;
		// pulse must stay high for the minimum width before it counts
		if (!tw_level) begin
			s_d.pulse_cnt = '0;
			s_d.pulse_ok = 1'b0;
		end else if (s_q.pulse_cnt != 23'(PULSE_CYC - 1)) begin
			s_d.pulse_cnt = s_q.pulse_cnt + 23'h1;
		end else begin
			s_d.pulse_ok = 1'b1;
		end
		if (tw_rise) begin
			s_d.pulse_ok = 1'b0;
		end
		if (!i_stop_closed_n) begin
			s_d.run_latch = 1'b0;
		end else if (s_q.pulse_ok) begin
			s_d.run_latch = 1'b1;
		end
		// slip compensation term grows with load
		if (i_control_method_code == CM_SLIP_COMP) begin
			s_d.slip_add = 16'((32'(s_q.slip_default) * 32'(i_motor_load_pct)) / 32'd100);
		end else begin
			s_d.slip_add = '0;
		end
		unique case (s_q.phase)
			PH_STOP: begin
				s_d.out_freq = '0;
				s_d.tick_cnt = '0;
				s_d.dwell_cnt = '0;
				if (s_q.run_latch) begin
					if (!s_q.dwell_done && i_dwell_time != 7'h00 && i_dwell_freq != 16'h0000) begin
						s_d.phase = PH_DWELL;
						// dwell level must show from the first dwell cycle
						s_d.out_freq = i_dwell_freq;
						s_d.dwell_done = 1'b1;
					end else begin
						s_d.phase = PH_ACCEL;
					end
				end else begin
					s_d.dwell_done = 1'b0;
				end
			end
			PH_DWELL: begin
				s_d.out_freq = i_dwell_freq;
				if (s_q.tick_cnt == 24'(TICK_CYC - 1)) begin
					s_d.tick_cnt = '0;
					s_d.dwell_cnt = s_q.dwell_cnt + 7'h1;
				end else begin
					s_d.tick_cnt = s_q.tick_cnt + 24'h1;
				end
				if (!s_q.run_latch) begin
					s_d.phase = PH_STOP;
				end else if (s_q.dwell_cnt >= i_dwell_time || s_q.dwell_cnt >= DWELL_TIME_MAX) begin
					s_d.phase = PH_ACCEL;
				end
			end
			PH_ACCEL: begin
				s_d.out_freq = step_to(s_q.out_freq, i_target_freq, i_accel_step);
				if (!s_q.run_latch) begin
					s_d.phase = PH_STOP;
				end else if (s_d.out_freq == i_target_freq) begin
					s_d.phase = PH_RUN;
				end
			end
			PH_RUN: begin
				s_d.out_freq = i_target_freq;
				if (!s_q.run_latch) begin
					s_d.phase = PH_STOP;
				end
			end
			default: begin
				s_d.phase = PH_STOP;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			s_q <= '{phase: PH_STOP, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign o_run_cmd = s_q.run_latch;
	assign o_dwell_active = (s_q.phase == PH_DWELL);
	assign o_slip_comp_en = (i_control_method_code == CM_SLIP_COMP);
	assign o_out_freq = (s_q.phase == PH_STOP) ? 16'h0000 : sat_add(s_q.out_freq, s_q.slip_add);
	assign o_slip_default = s_q.slip_default;

	// current defaults follow capacity, clamped to the settable range; efficiency is not clamped
	always_comb begin
		o_motor_defaults.rated_current = (i_motor_capacity_setting < CAP_MIN) ? 16'h0023
			: (i_motor_capacity_setting > CAP_MAX) ? 16'(CAP_MAX) * 16'h0023 : rated_i;
		o_motor_defaults.slip_freq = 16'h00c8;
		o_motor_defaults.no_load_current =
			16'((32'(o_motor_defaults.rated_current) * 32'(NOLOAD_PCT)) / 32'd100);
		o_motor_defaults.efficiency = 7'h46 + 7'(i_motor_capacity_setting >> 1);
	end

	always_comb begin
		o_inertia.inertia_low = (i_load_inertia_setting == INERTIA_LOW);
		o_inertia.inertia_ten = (i_load_inertia_setting == INERTIA_TEN);
		o_inertia.inertia_high = (i_load_inertia_setting == INERTIA_HIGH);
	end

endmodule

// ===== sim/drc_checker.sv
`timescale 1ns/1ns
module drc_checker
	import drc_pkg::*;
(
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_reset,
	// watched inputs
	input wire logic [4:0] i_input_function_code [NUM_INPUTS],
	input wire logic i_stop_closed_n,
	input wire logic [15:0] i_dwell_freq,
	input wire logic [6:0] i_dwell_time,
	input wire logic [1:0] i_control_method_code,
	input wire logic [1:0] i_load_inertia_setting,
	// watched outputs
	input wire logic o_run_cmd,
	input wire logic o_dwell_active,
	input wire logic o_slip_comp_en,
	input wire logic [15:0] o_out_freq,
	input wire drc_inertia_t o_inertia,
	input wire logic [NUM_INPUTS-1:0] o_code_valid
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);
	// stop may take a few edges to ramp the phase back
	sequence stop_held;
		!i_stop_closed_n [*5];
	endsequence
	a_code_ok: assert property (o_code_valid[2] == (i_input_function_code[2] <= FN_CODE_MAX))
		else $error("code valid flag wrong");
	a_slip_sel: assert property (o_slip_comp_en == (i_control_method_code == CM_SLIP_COMP))
		else $error("slip enable wrong");
	a_inertia_hot: assert property (o_inertia == {i_load_inertia_setting == INERTIA_LOW,
		i_load_inertia_setting == INERTIA_TEN, i_load_inertia_setting == INERTIA_HIGH})
		else $error("inertia decode wrong");
	a_stop_clears: assert property (!i_stop_closed_n |=> !o_run_cmd)
		else $error("run kept after stop");
	a_stop_idle: assert property (stop_held |-> o_out_freq == 16'h0 && !o_dwell_active)
		else $error("output not idle in stop");
	a_run_cause: assert property ($rose(o_run_cmd) |-> $past(i_stop_closed_n))
		else $error("run set while stop open");
	a_dwell_cause: assert property ($rose(o_dwell_active) |-> $past(o_run_cmd)
		&& i_dwell_time != 7'h0 && i_dwell_freq != 16'h0)
		else $error("dwell without cause");
	a_dwell_freq: assert property (o_dwell_active && !o_slip_comp_en && $stable(i_dwell_freq)
		|-> o_out_freq == i_dwell_freq)
		else $error("dwell frequency wrong");
	a_reset_idle: assert property ($fell(i_reset) |-> !o_run_cmd && o_out_freq == 16'h0)
		else $error("not idle after reset");
endmodule
bind drc_run_control drc_checker chk (.*);

// ===== sim/drc_operator_model.sv
`timescale 1ns/1ns
module drc_operator_model (
	// clock
	input wire logic i_sys_clk,
	// commands from the bench
	input wire logic i_press,
	input wire logic [23:0] i_hold_cyc,
	input wire logic i_stop_open,
	// switch contacts
	output logic o_button,
	output logic o_stop_closed_n
);
	initial o_button = 1'b0;
	always @(posedge i_press) begin
		o_button <= 1'b1;
		repeat (i_hold_cyc) @(negedge i_sys_clk);
		o_button <= 1'b0;
	end
	// normally closed contact opens when pressed
	assign o_stop_closed_n = !i_stop_open;
endmodule

// ===== sim/drc_run_control_bench.sv
`timescale 1ns/1ns
module drc_run_control_bench
	import drc_pkg::*;
;
	typedef struct packed {
		logic [1:0] inr, cm;
		logic [15:0] fr, rpm;
		logic [3:0] pl;
		logic [2:0] e_inr;
		logic e_en;
		logic [15:0] e_slip;
	} drc_row_t;
	drc_row_t rows [4] = '{'{2'h0, 2'h1, 16'h1770, 16'h06cc, 4'h4, 3'h4, 1'b1, 16'h00c8},
		'{2'h1, 2'h0, 16'h1388, 16'h05aa, 4'h4, 3'h2, 1'b0, 16'h00a7},
		'{2'h2, 2'h2, 16'h1770, 16'h0e10, 4'h2, 3'h1, 1'b0, 16'h0000},
		'{2'h3, 2'h3, 16'h1770, 16'h0708, 4'h6, 3'h0, 1'b0, 16'h0000}};
	logic [4:0] caps [2] = '{5'h01, 5'h16};
	logic i_sys_clk = 1'b0, i_reset = 1'b1, i_advanced_io = 1'b1, i_stop_closed_n;
	logic [NUM_INPUTS-1:0] i_terminals, o_code_valid;
	logic [4:0] i_input_function_code [NUM_INPUTS], i_motor_capacity_setting;
	logic [15:0] i_dwell_freq = 16'h01f4, i_target_freq = 16'h1770, i_accel_step = 16'h0100;
	logic [23:0] hold = 24'h000032;
	logic [15:0] i_rated_freq, i_rated_rpm, i_motor_load_pct = 16'h0032, o_out_freq, o_slip_default;
	logic [6:0] i_dwell_time = 7'h05;
	logic [1:0] i_control_method_code, i_load_inertia_setting;
	logic [3:0] i_pole_count_setting;
	logic o_run_cmd, o_dwell_active, o_slip_comp_en, press = 1'b0, stop_open = 1'b0, button;
	drc_motor_t o_motor_defaults;
	drc_inertia_t o_inertia;
	int errors = 0, total_checks = 0, cyc = 0;
	assign i_terminals = {2'h0, button, 2'h0};
	drc_run_control #(.PULSE_CYC(100), .TICK_CYC(20)) dut (.*);
	drc_operator_model op (.i_sys_clk(i_sys_clk), .i_press(press), .i_hold_cyc(hold),
		.i_stop_open(stop_open), .o_button(button), .o_stop_closed_n(i_stop_closed_n));
	initial forever #4 i_sys_clk = !i_sys_clk;
	task automatic check(string n, logic [15:0] e, logic [15:0] s);
		total_checks++;
		if (s !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task tally_and_finish;
		$display("errors %0d checks %0d", errors, total_checks);
		if (errors == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge i_sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			tally_and_finish;
		end
	end
	initial begin
		foreach (i_input_function_code[k]) i_input_function_code[k] = 5'h00;
		i_control_method_code = 2'h0;
		i_load_inertia_setting = 2'h0;
		i_motor_capacity_setting = 5'h01;
		{i_rated_freq, i_rated_rpm, i_pole_count_setting} = '0;
		repeat (20) @(negedge i_sys_clk);
		i_reset = 1'b0;
		@(negedge i_sys_clk);
		check("run after reset", 16'h0, o_run_cmd);
		check("freq after reset", 16'h0, o_out_freq);
		foreach (rows[k]) begin
			i_load_inertia_setting = rows[k].inr;
			i_control_method_code = rows[k].cm;
			i_rated_freq = rows[k].fr;
			i_rated_rpm = rows[k].rpm;
			i_pole_count_setting = rows[k].pl;
			repeat (3) @(negedge i_sys_clk);
			check("inertia", 16'(rows[k].e_inr), 16'(o_inertia));
			check("slip enable", 16'(rows[k].e_en), 16'(o_slip_comp_en));
			check("slip default", rows[k].e_slip, o_slip_default);
		end
		for (int c = 0; c < 32; c++) begin
			i_input_function_code[2] = 5'(c);
			@(negedge i_sys_clk);
			check("code valid", 16'(5'(c) <= FN_CODE_MAX), 16'(o_code_valid[2]));
		end
		foreach (caps[k]) begin
			i_motor_capacity_setting = caps[k];
			@(negedge i_sys_clk);
			check("rated current", 16'(caps[k]) * 16'h0023, o_motor_defaults.rated_current);
			check("no load", 16'(caps[k]) * 16'h000e, o_motor_defaults.no_load_current);
			check("efficiency", 16'h0046 + 16'(caps[k] / 2), 16'(o_motor_defaults.efficiency));
		end
		// pulse minimum shortened to 100 cycles; 50 is too short
		i_input_function_code[2] = FN_THREE_WIRE;
		press = 1'b1;
		@(negedge i_sys_clk);
		press = 1'b0;
		repeat (1100) @(negedge i_sys_clk);
		check("short press run", 16'h0, o_run_cmd);
		hold = 24'h0000c8;
		press = 1'b1;
		@(negedge i_sys_clk);
		press = 1'b0;
		repeat (150) @(negedge i_sys_clk);
		check("long press run", 16'h1, o_run_cmd);
		check("dwell active", 16'h1, o_dwell_active);
		check("dwell freq", i_dwell_freq, o_out_freq);
		repeat (300) @(negedge i_sys_clk);
		check("held run", 16'h1, o_run_cmd);
		check("dwell over", 16'h0, o_dwell_active);
		check("run freq", i_target_freq, o_out_freq);
		stop_open = 1'b1;
		repeat (6) @(negedge i_sys_clk);
		check("stop run", 16'h0, o_run_cmd);
		check("stop freq", 16'h0, o_out_freq);
		stop_open = 1'b0;
		i_dwell_time = 7'h00;
		@(negedge i_sys_clk);
		press = 1'b1;
		@(negedge i_sys_clk);
		press = 1'b0;
		repeat (150) @(negedge i_sys_clk);
		check("zero time run", 16'h1, o_run_cmd);
		check("zero time dwell", 16'h0, o_dwell_active);
		tally_and_finish;
	end
endmodule
